// *** hdl/sbs_pkg.sv ***
/*
 * Shared constants and the state record of the serial buffer status block.
 * Assumes a 32-bit classic Wishbone bus and a transfer engine on the same clock.
 */
package sbs_pkg;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [3:0] SBS_ADR_TXBUF   = 4'h0;
    localparam logic [3:0] SBS_ADR_RXBUF   = 4'h4;
    localparam logic [3:0] SBS_ADR_MODE2   = 4'h8;

    // ==========================================================
    // serial_mode_control_two field positions
    localparam int SBS_BIT_TBEMP    = 7;
    localparam int SBS_BIT_RX_FULL  = 6;
    localparam int SBS_BIT_TXRUN    = 5;
    localparam int SBS_BIT_STOP_LEN = 4;
    localparam int SBS_BIT_ORDER    = 3;
    localparam int SBS_BIT_DBUF_EN  = 2;
    localparam int SBS_BIT_SOFT_KEY = 0;
    localparam int SBS_SOFT_KEY_W   = 2;

    // ==========================================================
    // reset values and soft reset key sequence
    localparam logic       SBS_RST_TBEMP    = 1'b1;
    localparam logic       SBS_RST_RX_FULL  = 1'b0;
    localparam logic [1:0] SBS_SOFT_KEY_ARM = 2'h2;
    localparam logic [1:0] SBS_SOFT_KEY_GO  = 2'h1;

    localparam int SBS_DATA_W = 9;

    typedef struct packed {
        logic                  ack;
        logic [31:0]           rdata;
        logic                  tbemp;
        logic                  rx_full;
        logic                  txrun;
        logic                  stop_len;
        logic                  bit_order;
        logic                  dbuf_en;
        logic [1:0]            soft_key;
        logic                  soft_rst;
        logic [SBS_DATA_W-1:0] txbuf;
        logic [SBS_DATA_W-1:0] rxbuf;
    } sbs_state_t;

endpackage : sbs_pkg

// *** hdl/sbs_status.sv ***
/*
 * Status flags of the second serial mode register, with the transmit and
 * receive double buffers and a classic Wishbone slave.
 * Assumes the transfer engine runs on CLOCK_I and gives same-clock strobes.
 */
// Chosen here: the Wishbone register port and the address map.
// Behaviour
// - bit 7 reads 1 when transmit buffer empty, 0 when full; resets to 1
// - transmit empty flag sets when buffer moves into shift register
// - software write of a new transmit word clears the empty flag
// - with double buffering off both buffer flags are meaningless to software
// - receive full sets on completed reception, clears when software reads it
// - bit 5 reads 1 while transmitting, 0 when transmitter stopped
// - with bit 5 low, empty means done, not empty means waiting
`timescale 1ns/1ps
module sbs_status
    import sbs_pkg::*;
(
    input  wire logic                  CLOCK_I,
    input  wire logic                  RST_N_I,
    input  wire logic                  CE_I,
    input  wire logic                  WB_CYC_I,
    input  wire logic                  WB_STB_I,
    input  wire logic                  WB_WE_I,
    input  wire logic [3:0]            WB_ADR_I,
    input  wire logic [3:0]            WB_SEL_I,
    input  wire logic [31:0]           WB_DAT_I,
    output logic      [31:0]           WB_DAT_O,
    output logic                       WB_ACK_O,
    input  wire logic                  TX_LOAD_SHIFT_I,
    input  wire logic                  TX_SHIFT_BUSY_I,
    input  wire logic                  RX_DONE_I,
    input  wire logic [SBS_DATA_W-1:0] RX_DATA_I,
    output logic      [SBS_DATA_W-1:0] TX_DATA_O,
    output logic                       TX_BUF_EMPTY_O,
    output logic                       STOP_BIT_LENGTH_O,
    output logic                       BIT_ORDER_SELECT_O,
    output logic                       DOUBLE_BUFFER_ENABLE_O,
    output logic                       SOFT_RESET_O
);

    // ==========================================================
    // state record and its next value
    sbs_state_t s_q;
    sbs_state_t s_d;

    // ==========================================================
    // helper nets
    logic        req;
    logic        wr;
    logic        rd;
    logic        wr_low;

    logic        hit_txbuf;
    logic        hit_rxbuf;
    logic        hit_mode2;

    logic        tx_write;
    logic        rx_read;
    logic        mode_write;

    logic [1:0]  key_new;
    logic        key_hit;

    logic        tx_set;
    logic        tx_clr;
    logic        rx_set;
    logic        rx_clr;

    logic [7:0]  mode2_view;
    logic [31:0] rd_word;

    // ==========================================================
    // bus decode
    // side effects happen on the edge that raises ack, one edge before the
    // master samples it; the request is held so nothing is repeated
    assign req        = WB_CYC_I & WB_STB_I & ~s_q.ack;
    assign wr         = req & WB_WE_I;
    assign rd         = req & ~WB_WE_I;
    // only byte lane 0 enables a write, but txbuf bit 8 comes from lane 1
    assign wr_low     = wr & WB_SEL_I[0];

    assign hit_txbuf  = (WB_ADR_I == SBS_ADR_TXBUF);
    assign hit_rxbuf  = (WB_ADR_I == SBS_ADR_RXBUF);
    assign hit_mode2  = (WB_ADR_I == SBS_ADR_MODE2);

    // a read of the transmit buffer or a write of the receive buffer
    // decodes to nothing and is simply acknowledged
    assign tx_write   = wr_low & hit_txbuf;
    assign rx_read    = rd & hit_rxbuf;
    assign mode_write = wr_low & hit_mode2;

    // ==========================================================
    // soft reset key
    // fires only when the old field holds the arm code, so a single
    // careless write of the go code does nothing
    assign key_new = WB_DAT_I[SBS_BIT_SOFT_KEY +: SBS_SOFT_KEY_W];
    assign key_hit = mode_write
                   & (s_q.soft_key == SBS_SOFT_KEY_ARM)
                   & (key_new == SBS_SOFT_KEY_GO);

    // ==========================================================
    // flag events
    // engine strobes share CLOCK_I, so no synchroniser sits in front
    assign tx_set = TX_LOAD_SHIFT_I;
    assign tx_clr = tx_write;
    assign rx_set = RX_DONE_I;
    assign rx_clr = rx_read;

    // ==========================================================
    // register view
    // bit 5 is the registered busy level, so it lags the engine a cycle
    always_comb begin
        mode2_view                                     = 8'h00;
        mode2_view[SBS_BIT_TBEMP]                      = s_q.tbemp;
        mode2_view[SBS_BIT_RX_FULL]                    = s_q.rx_full;
        mode2_view[SBS_BIT_TXRUN]                      = s_q.txrun;
        mode2_view[SBS_BIT_STOP_LEN]                   = s_q.stop_len;
        mode2_view[SBS_BIT_ORDER]                      = s_q.bit_order;
        mode2_view[SBS_BIT_DBUF_EN]                    = s_q.dbuf_en;
        mode2_view[SBS_BIT_SOFT_KEY +: SBS_SOFT_KEY_W] = s_q.soft_key;
    end

    // upper bits of every register read as zero
    always_comb begin
        rd_word = 32'h00000000;
        case (WB_ADR_I)
            SBS_ADR_RXBUF: begin
                rd_word = {{(32-SBS_DATA_W){1'b0}}, s_q.rxbuf};
            end
            SBS_ADR_MODE2: begin
                rd_word = {24'h000000, mode2_view};
            end
            default: begin
                rd_word = 32'h00000000;
            end
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        s_d          = s_q;
        s_d.ack      = req;
        s_d.soft_rst = 1'b0;

        // transmit activity tracks the engine one cycle late; with it low
        // the empty flag alone tells done from waiting
        s_d.txrun    = TX_SHIFT_BUSY_I;

        // flags move regardless of double-buffer enable; software ignores
        // them then. a write in the cycle of a load wins: the new word
        // really sits in the buffer, so full is the honest answer
        if (tx_clr) begin
            s_d.tbemp = 1'b0;
        end else if (tx_set) begin
            s_d.tbemp = 1'b1;
        end

        // a word arriving in the cycle of a read keeps the flag set
        if (rx_set) begin
            s_d.rx_full = 1'b1;
            s_d.rxbuf   = RX_DATA_I;
        end else if (rx_clr) begin
            s_d.rx_full = 1'b0;
        end

        if (tx_write) begin
            s_d.txbuf = WB_DAT_I[SBS_DATA_W-1:0];
        end

        // status and reserved bits are not written
        if (mode_write) begin
            s_d.stop_len  = WB_DAT_I[SBS_BIT_STOP_LEN];
            s_d.bit_order = WB_DAT_I[SBS_BIT_ORDER];
            s_d.dbuf_en   = WB_DAT_I[SBS_BIT_DBUF_EN];
            s_d.soft_key  = key_new;
        end

        // the soft reset returns both buffer flags to their reset values
        // but leaves the mode fields as just written
        if (key_hit) begin
            s_d.soft_rst = 1'b1;
            s_d.tbemp    = SBS_RST_TBEMP;
            s_d.rx_full  = SBS_RST_RX_FULL;
        end

        // read data holds until the next read
        if (rd) begin
            s_d.rdata = rd_word;
        end

        // clock enable low freezes everything, ack included
        if (!CE_I) begin
            s_d = s_q;
        end
    end

    // ==========================================================
    // state register
    // reset loads constants only
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            s_q         <= '0;
            s_q.tbemp   <= SBS_RST_TBEMP;
            s_q.rx_full <= SBS_RST_RX_FULL;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs, all straight from the state record
    // software sees a flag one cycle after the event that moved it
    assign WB_DAT_O               = s_q.rdata;
    assign WB_ACK_O               = s_q.ack;
    assign TX_DATA_O              = s_q.txbuf;
    assign TX_BUF_EMPTY_O         = s_q.tbemp;
    assign STOP_BIT_LENGTH_O      = s_q.stop_len;
    assign BIT_ORDER_SELECT_O     = s_q.bit_order;
    assign DOUBLE_BUFFER_ENABLE_O = s_q.dbuf_en;
    assign SOFT_RESET_O           = s_q.soft_rst;

endmodule : sbs_status

// *** sim/sbs_engine_model.sv ***
/* transfer engine stand-in: loads the tx buffer, shifts 32 cycles, delivers words.
   assumes the bench pulses its commands for one cycle. */
`timescale 1ns/1ps
module sbs_engine_model (
    input  wire logic       clk_i, rst_n_i, go_tx_i, go_rx_i,
    input  wire logic [8:0] word_i,
    output logic            load_o, busy_o, done_o,
    output logic      [8:0] rxd_o
);
    // ==========================================
    // engine
    logic [5:0] cnt_q;
    assign busy_o = cnt_q != 6'h0;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {load_o, done_o, cnt_q, rxd_o} <= '0;
        end else begin
            load_o <= go_tx_i;
            done_o <= go_rx_i;
            // word valid only with done, else it toggles
            rxd_o  <= go_rx_i ? word_i : ~rxd_o;
            cnt_q  <= go_tx_i ? 6'h20 : cnt_q - {5'h0, busy_o};
        end
    end
endmodule : sbs_engine_model

// *** sim/sbs_status_chk.sv ***
/* bus and flag timing checks for sbs_status.
   assumes the bind below attaches it; CE_I low freezes the block. */
`timescale 1ns/1ps
module sbs_status_chk
    import sbs_pkg::*;
(
    input wire logic CLOCK_I, RST_N_I, CE_I, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O,
    input wire logic TX_LOAD_SHIFT_I, TX_SHIFT_BUSY_I, RX_DONE_I, TX_BUF_EMPTY_O,
    input wire logic [3:0] WB_ADR_I, WB_SEL_I,
    input wire logic [31:0] WB_DAT_I, WB_DAT_O,
    input wire logic [SBS_DATA_W-1:0] RX_DATA_I, TX_DATA_O
);
    // ==========================================
    // taken requests
    wire tk = WB_CYC_I && WB_STB_I && !WB_ACK_O && CE_I;
    wire wt = tk && WB_WE_I && WB_ADR_I == SBS_ADR_TXBUF && WB_SEL_I[0];
    wire wm = tk && WB_WE_I && WB_ADR_I == SBS_ADR_MODE2;
    wire rm = tk && !WB_WE_I && WB_ADR_I == SBS_ADR_MODE2;
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);
    sequence s_pulse; WB_ACK_O ##1 !WB_ACK_O; endsequence
    property p_ack; tk |=> s_pulse; endproperty
    a_ack: assert property (p_ack) else $error("ack not a one cycle answer");
    property p_noack; CE_I && !(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O; endproperty
    a_noack: assert property (p_noack) else $error("ack without request");
    property p_set; CE_I && TX_LOAD_SHIFT_I && !wt |=> TX_BUF_EMPTY_O; endproperty
    a_set: assert property (p_set) else $error("empty flag not set on load");
    property p_clr; wt |=> !TX_BUF_EMPTY_O; endproperty
    a_clr: assert property (p_clr) else $error("empty flag not cleared on write");
    property p_hold; !TX_LOAD_SHIFT_I && !wt && !wm |=> $stable(TX_BUF_EMPTY_O); endproperty
    a_hold: assert property (p_hold) else $error("empty flag moved by itself");
    property p_txd; wt |=> TX_DATA_O == SBS_DATA_W'($past(WB_DAT_I)); endproperty
    a_txd: assert property (p_txd) else $error("tx buffer word wrong");
    property p_rd; rm |=> WB_DAT_O[31:8] == 24'h0 && WB_DAT_O[7] == $past(TX_BUF_EMPTY_O); endproperty
    a_rd: assert property (p_rd) else $error("mode read wrong");
    property p_run; rm && $stable(TX_SHIFT_BUSY_I) |=> WB_DAT_O[5] == $past(TX_SHIFT_BUSY_I); endproperty
    a_run: assert property (p_run) else $error("running flag wrong");
endmodule : sbs_status_chk
bind sbs_status sbs_status_chk u_chk (.CLOCK_I, .RST_N_I, .CE_I, .WB_CYC_I, .WB_STB_I, .WB_WE_I,
    .WB_ACK_O, .TX_LOAD_SHIFT_I, .TX_SHIFT_BUSY_I, .RX_DONE_I, .TX_BUF_EMPTY_O, .WB_ADR_I,
    .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .RX_DATA_I, .TX_DATA_O);

// *** sim/sbs_status_tb_top.sv ***
/* bench for sbs_status: wishbone calls against the engine model.
   assumes the checker binds itself to uut. */
`timescale 1ns/1ps
module sbs_status_tb_top;
    import sbs_pkg::*;
    // ==========================================
    // harness
    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, we = 1'b0, go_tx = 1'b0, go_rx = 1'b0, ce = 1'b1;
    logic [3:0]  adr = 4'h0;
    logic [31:0] dat = 32'h0, dq, q;
    logic        ack, ld, bsy, dn, tbe, dbe, sbl, bor, srst;
    logic [8:0]  rxd, txd;
    int          fails = 0, tests_run = 0, srst_cnt = 0;
    always #2 clk = ~clk;
    // counts soft reset pulses, so the one-cycle output is never missed
    always @(posedge clk) begin
        if (srst === 1'b1) begin
            srst_cnt <= srst_cnt + 1;
        end
    end
    sbs_engine_model u_eng (.clk_i(clk), .rst_n_i(rst_n), .go_tx_i(go_tx), .go_rx_i(go_rx),
        .word_i(9'h15A), .load_o(ld), .busy_o(bsy), .done_o(dn), .rxd_o(rxd));
    sbs_status uut (.CLOCK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .WB_CYC_I(cyc), .WB_STB_I(cyc),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_DAT_O(dq), .WB_ACK_O(ack),
        .TX_LOAD_SHIFT_I(ld), .TX_SHIFT_BUSY_I(bsy), .RX_DONE_I(dn), .RX_DATA_I(rxd), .TX_DATA_O(txd),
        .TX_BUF_EMPTY_O(tbe), .STOP_BIT_LENGTH_O(sbl), .BIT_ORDER_SELECT_O(bor),
        .DOUBLE_BUFFER_ENABLE_O(dbe), .SOFT_RESET_O(srst));
    task automatic finish_test;
        $display("fails %0d tests_run %0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("Error %0t: saw %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, we, adr, dat} <= {1'b1, w, a, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dq;
        cyc <= 1'b0;
        if (ack !== 1'b1) begin
            fails++;
            finish_test();
        end
    endtask : wb
    task automatic rm(input logic [31:0] e);
        wb(1'b0, SBS_ADR_MODE2, 32'h0);
        chk(q, e);
    endtask : rm
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rm(32'h80);
        chk({31'h0, tbe}, 32'h1);
        $display("reset test done");
        wb(1'b1, SBS_ADR_TXBUF, 32'h1A5);
        chk({23'h0, txd}, 32'h1A5);
        rm(32'h00);
        go_tx <= 1'b1;
        @(posedge clk);
        go_tx <= 1'b0;
        rm(32'hA0);
        repeat (40) @(posedge clk);
        rm(32'h80);
        $display("tx test done");
        go_rx <= 1'b1;
        @(posedge clk);
        go_rx <= 1'b0;
        rm(32'hC0);
        wb(1'b0, SBS_ADR_RXBUF, 32'h0);
        chk(q, 32'h15A);
        rm(32'h80);
        $display("rx test done");
        wb(1'b1, SBS_ADR_MODE2, 32'hFFFF_FF5C);
        rm(32'h9C);
        chk({31'h0, dbe}, 32'h1);
        chk({30'h0, sbl, bor}, 32'h3);
        wb(1'b0, 4'hC, 32'h0);
        chk(q, 32'h0);
        $display("mode test done");
        wb(1'b1, SBS_ADR_TXBUF, 32'h0AB);
        go_rx <= 1'b1;
        @(posedge clk);
        go_rx <= 1'b0;
        wb(1'b1, SBS_ADR_MODE2, 32'h2);
        rm(32'h42);
        wb(1'b1, SBS_ADR_MODE2, 32'h1);
        rm(32'h81);
        chk(srst_cnt, 32'h1);
        ce <= 1'b0;
        go_rx <= 1'b1;
        @(posedge clk);
        go_rx <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        rm(32'h81);
        $display("soft reset test done");
        finish_test();
    end
endmodule : sbs_status_tb_top
